//--- sswd_host_model.sv
// host side model: periodic watchdog kicks and a manual reset button
`timescale 1ns/1ps
module sswd_host_model (
    input wire logic sys_clk,
    input wire logic kick_en,
    input wire logic [7:0] kick_period,
    input wire logic press,
    output logic watchdog_kick_n,
    output logic manual_reset_n
);
    logic [7:0] cnt;

    initial begin
        cnt = 8'h00;
        watchdog_kick_n = 1'b1;
    end

    // ============================================================
    // kick low two cycles every period; short pulse keeps well under the shortest timeout
    always @(posedge sys_clk) begin
        cnt <= (kick_en && cnt < kick_period) ? cnt + 8'h01 : 8'h00;
        watchdog_kick_n <= !(kick_en && cnt < 8'h02);
    end

    // released button reads high, as the pull-up would make it
    assign manual_reset_n = !press;
endmodule

//--- sswd_pkg.sv
// constants, types and helpers shared by the supply supervisor watchdog
// ============================================================
// ============================================================
package sswd_pkg;

    // ============================================================
    // timebase
    localparam longint unsigned SSWD_CLK_HZ = 200_000_000;
    localparam longint unsigned SSWD_MS_PER_S = 1000;

    // ============================================================
    // times in milliseconds, as printed
    localparam int unsigned SSWD_HOLD_MS = 250;
    localparam int unsigned SSWD_PB_LOW_MS = 20;
    localparam int unsigned SSWD_TO_SHORT_MS = 150;
    localparam int unsigned SSWD_TO_MID_MS = 600;
    localparam int unsigned SSWD_TO_LONG_MS = 1200;

    // least time rounded up to whole cycles, never under one
    function automatic logic [31:0] sswd_ms_to_cyc(input int unsigned ms);
        longint unsigned prod;
        prod = (longint'(ms) * SSWD_CLK_HZ + SSWD_MS_PER_S - 1) / SSWD_MS_PER_S;
        if (prod == 0) begin
            prod = 1;
        end
        return prod[31:0];
    endfunction

    localparam logic [31:0] SSWD_HOLD_CYC = sswd_ms_to_cyc(SSWD_HOLD_MS);
    localparam logic [31:0] SSWD_PB_LOW_CYC = sswd_ms_to_cyc(SSWD_PB_LOW_MS);
    localparam logic [31:0] SSWD_TO_SHORT_CYC = sswd_ms_to_cyc(SSWD_TO_SHORT_MS);
    localparam logic [31:0] SSWD_TO_MID_CYC = sswd_ms_to_cyc(SSWD_TO_MID_MS);
    localparam logic [31:0] SSWD_TO_LONG_CYC = sswd_ms_to_cyc(SSWD_TO_LONG_MS);
    localparam logic [31:0] SSWD_CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] SSWD_CNT_ONE = 32'h0000_0001;

    // ============================================================
    // three-level timeout select, sensed as two comparator bits
    typedef enum logic [1:0] {
        SSWD_TSEL_GND = 2'h0,
        SSWD_TSEL_FLOAT = 2'h1,
        SSWD_TSEL_SUPPLY = 2'h2,
        SSWD_TSEL_BAD = 2'h3
    } sswd_tsel_t;

    // supervisor state, gray along hold -> run -> hold
    typedef enum logic [0:0] {
        SSWD_ST_HOLD = 1'h0,
        SSWD_ST_RUN = 1'h1
    } sswd_state_t;

    // asynchronous pin group, crosses together through the synchroniser
    typedef struct packed {
        logic supply_ok_tight;
        logic supply_ok_loose;
        logic trip_margin_sel;
        sswd_tsel_t timeout_select;
        logic manual_reset_n;
        logic watchdog_kick_n;
    } sswd_pins_t;

    // reset values of the synchronised pins: supply bad, buttons released
    localparam sswd_pins_t SSWD_PINS_RST = '{
        supply_ok_tight: 1'h0,
        supply_ok_loose: 1'h0,
        trip_margin_sel: 1'h0,
        timeout_select: SSWD_TSEL_GND,
        manual_reset_n: 1'h1,
        watchdog_kick_n: 1'h1
    };

endpackage

//--- sswd_supervisor.sv
// supply supervisor with manual reset debounce and watchdog
`timescale 1ns/1ps
module sswd_supervisor
    import sswd_pkg::*;
#(
    parameter logic [31:0] HOLD_CYC = sswd_pkg::SSWD_HOLD_CYC,
    parameter logic [31:0] PB_LOW_CYC = sswd_pkg::SSWD_PB_LOW_CYC,
    parameter logic [31:0] TO_SHORT_CYC = sswd_pkg::SSWD_TO_SHORT_CYC,
    parameter logic [31:0] TO_MID_CYC = sswd_pkg::SSWD_TO_MID_CYC,
    parameter logic [31:0] TO_LONG_CYC = sswd_pkg::SSWD_TO_LONG_CYC
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic supply_ok_tight,
    input wire logic supply_ok_loose,
    input wire logic trip_margin_sel,
    input wire logic [1:0] timeout_select,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_n,
    output logic reset_out,
    output logic reset_out_n
);
    import sswd_pkg::*;

    // ============================================================
    // pin synchronisation
    sswd_pins_t pins_async;
    sswd_pins_t pins;

    always_comb begin
        pins_async.supply_ok_tight = supply_ok_tight;
        pins_async.supply_ok_loose = supply_ok_loose;
        pins_async.trip_margin_sel = trip_margin_sel;
        pins_async.timeout_select = sswd_tsel_t'(timeout_select);
        pins_async.manual_reset_n = manual_reset_n;
        pins_async.watchdog_kick_n = watchdog_kick_n;
    end

    sswd_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pins_async(pins_async),
        .pins_sync(pins)
    );

    // saturating increment, shared by all three timers
    function automatic logic [31:0] sswd_inc(input logic [31:0] cnt);
        return (cnt == '1) ? cnt : cnt + SSWD_CNT_ONE;
    endfunction

    // ============================================================
    // undervoltage request
    logic uv_req;

    // tight margin on a low select, loose on a high one
    always_comb begin
        uv_req = pins.trip_margin_sel ? !pins.supply_ok_loose : !pins.supply_ok_tight;
    end

    // ============================================================
    // manual reset debounce
    logic [31:0] pb_cnt;
    logic [31:0] next_pb_cnt;
    logic pb_req;
    logic next_pb_req;

    // request only once low has held for the full low time, so bounce never reaches the hold
    always_comb begin
        next_pb_cnt = pb_cnt;
        next_pb_req = pb_req;
        if (pins.manual_reset_n) begin
            next_pb_cnt = SSWD_CNT_ZERO;
            next_pb_req = 1'b0;
        end else begin
            next_pb_cnt = sswd_inc(pb_cnt);
            if (pb_cnt >= PB_LOW_CYC - SSWD_CNT_ONE) begin
                next_pb_req = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pb_cnt <= SSWD_CNT_ZERO;
            pb_req <= 1'b0;
        end else begin
            pb_cnt <= next_pb_cnt;
            pb_req <= next_pb_req;
        end
    end

    // ============================================================
    // watchdog
    logic kick_prev;
    logic next_kick_prev;
    logic kick_take;
    logic [31:0] wd_cnt;
    logic [31:0] next_wd_cnt;
    logic [31:0] wd_limit;
    logic wd_expire;
    sswd_state_t state;
    sswd_state_t next_state;

    // illegal select code falls back to the shortest period, the safe side
    always_comb begin
        unique case (pins.timeout_select)
            SSWD_TSEL_GND: wd_limit = TO_SHORT_CYC;
            SSWD_TSEL_FLOAT: wd_limit = TO_MID_CYC;
            SSWD_TSEL_SUPPLY: wd_limit = TO_LONG_CYC;
            default: wd_limit = TO_SHORT_CYC;
        endcase
    end

    // no enable input exists: in run only an accepted falling edge holds the timer off; the hold state keeps it at zero
    always_comb begin
        next_kick_prev = pins.watchdog_kick_n;
        kick_take = kick_prev && !pins.watchdog_kick_n && (state == SSWD_ST_RUN);
        wd_expire = (state == SSWD_ST_RUN) && (wd_cnt >= wd_limit - SSWD_CNT_ONE) && !kick_take;
        if (state != SSWD_ST_RUN) begin
            next_wd_cnt = SSWD_CNT_ZERO;
        end else if (kick_take || wd_expire) begin
            next_wd_cnt = SSWD_CNT_ZERO;
        end else begin
            next_wd_cnt = sswd_inc(wd_cnt);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kick_prev <= 1'b1;
            wd_cnt <= SSWD_CNT_ZERO;
        end else begin
            kick_prev <= next_kick_prev;
            wd_cnt <= next_wd_cnt;
        end
    end

    // ============================================================
    // merged reset state and hold timer
    logic any_req;
    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    logic next_reset_out;

    // any request reloads the hold, so overlapping causes extend it
    always_comb begin
        any_req = uv_req || pb_req || wd_expire;
        next_state = state;
        next_hold_cnt = hold_cnt;
        unique case (state)
            SSWD_ST_RUN: begin
                next_hold_cnt = SSWD_CNT_ZERO;
                if (any_req) begin
                    next_state = SSWD_ST_HOLD;
                end
            end
            SSWD_ST_HOLD: begin
                if (any_req) begin
                    next_hold_cnt = SSWD_CNT_ZERO;
                end else if (hold_cnt >= HOLD_CYC - SSWD_CNT_ONE) begin
                    next_state = SSWD_ST_RUN;
                    next_hold_cnt = SSWD_CNT_ZERO;
                end else begin
                    next_hold_cnt = sswd_inc(hold_cnt);
                end
            end
        endcase
        next_reset_out = (next_state == SSWD_ST_HOLD);
    end

    // both outputs load from one next value, so they never disagree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SSWD_ST_HOLD;
            hold_cnt <= SSWD_CNT_ZERO;
            reset_out <= 1'b1;
            reset_out_n <= 1'b0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            reset_out <= next_reset_out;
            reset_out_n <= !next_reset_out;
        end
    end

    // ============================================================
    // assertions
    sequence s_kick_edge;
        kick_prev && !pins.watchdog_kick_n;
    endsequence

    sequence s_hold_done;
        (state == SSWD_ST_HOLD) && !any_req && (hold_cnt == HOLD_CYC - SSWD_CNT_ONE);
    endsequence

    a_outputs_complement: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reset_out == !reset_out_n)
        else $error("reset outputs are not complementary");

    a_margin_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!pins.trip_margin_sel && !pins.supply_ok_tight) || (pins.trip_margin_sel && !pins.supply_ok_loose)
        |=> reset_out)
        else $error("selected undervoltage did not assert reset");

    a_hold_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(reset_out) |-> $past(hold_cnt) == HOLD_CYC - SSWD_CNT_ONE && !$past(any_req))
        else $error("reset released before full hold time");

    a_uv_persists: assert property (@(posedge sys_clk) disable iff (!arst_n)
        uv_req [*2] |-> reset_out && state == SSWD_ST_HOLD && hold_cnt == SSWD_CNT_ZERO)
        else $error("reset not held during undervoltage");

    a_manual_debounce: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(pb_req) |-> $past(pb_cnt) >= PB_LOW_CYC - SSWD_CNT_ONE && $past(!pins.manual_reset_n))
        else $error("manual request without full low time");

    a_manual_asserts: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pb_req |=> reset_out)
        else $error("manual request did not assert reset");

    a_wd_expiry: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wd_expire |=> reset_out && hold_cnt == SSWD_CNT_ZERO)
        else $error("watchdog timeout did not start a reset hold");

    a_wd_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_hold_done |=> !reset_out && wd_cnt == SSWD_CNT_ZERO)
        else $error("watchdog did not restart at release");

    // expected period decoded here on its own, so a wrong limit mux cannot hide behind itself
    a_wd_period: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_RUN && !kick_take && wd_cnt == (pins.timeout_select == SSWD_TSEL_FLOAT ? TO_MID_CYC
        : pins.timeout_select == SSWD_TSEL_SUPPLY ? TO_LONG_CYC : TO_SHORT_CYC) - SSWD_CNT_ONE
        |=> reset_out)
        else $error("watchdog missed its selected period");

    a_kick_ignored: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reset_out ##0 s_kick_edge |-> !kick_take ##1 wd_cnt == SSWD_CNT_ZERO)
        else $error("kick accepted during reset");

    a_kick_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !reset_out ##0 s_kick_edge |=> wd_cnt == SSWD_CNT_ZERO)
        else $error("kick did not clear the watchdog");

    a_hold_extend: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_HOLD && any_req |=> state == SSWD_ST_HOLD && hold_cnt == SSWD_CNT_ZERO)
        else $error("new request did not restart the hold");

    // running with no manual or watchdog request pending
    sequence s_run_quiet;
        (state == SSWD_ST_RUN) && !pb_req && !wd_expire;
    endsequence

    // running, no kick and no expiry this cycle
    sequence s_wd_idle;
        (state == SSWD_ST_RUN) && !kick_take && !wd_expire;
    endsequence

    a_tight_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_run_quiet ##0 (!pins.trip_margin_sel && pins.supply_ok_tight) |=> !reset_out)
        else $error("unselected loose comparator caused a reset");

    a_loose_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_run_quiet ##0 (pins.trip_margin_sel && pins.supply_ok_loose) |=> !reset_out)
        else $error("unselected tight comparator caused a reset");

    a_pb_release_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pins.manual_reset_n |=> pb_cnt == SSWD_CNT_ZERO && !pb_req)
        else $error("manual release did not clear the debounce");

    a_pb_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !pins.manual_reset_n && pb_cnt != '1 |=> pb_cnt == $past(pb_cnt) + SSWD_CNT_ONE)
        else $error("debounce count did not advance while low");

    a_pb_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pb_req |=> state == SSWD_ST_HOLD && hold_cnt == SSWD_CNT_ZERO)
        else $error("manual request did not restart the hold");

    a_hold_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_HOLD && !any_req && hold_cnt < HOLD_CYC - SSWD_CNT_ONE
        |=> state == SSWD_ST_HOLD && hold_cnt == $past(hold_cnt) + SSWD_CNT_ONE)
        else $error("hold timer did not advance");

    a_wd_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_wd_idle |=> wd_cnt == $past(wd_cnt) + SSWD_CNT_ONE)
        else $error("watchdog timer stalled without a kick");

    a_wd_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_HOLD |-> !kick_take && !wd_expire)
        else $error("watchdog active during reset");

    a_hold_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_HOLD |=> wd_cnt == SSWD_CNT_ZERO)
        else $error("watchdog timer not held at zero in reset");

    a_reset_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_HOLD |-> reset_out && !reset_out_n)
        else $error("reset outputs not asserted in hold");

    a_run_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state == SSWD_ST_RUN |-> !reset_out && reset_out_n)
        else $error("reset outputs not released in run");
endmodule

//--- sswd_supervisor_tb.sv
// self-checking bench for the supply supervisor watchdog
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module sswd_supervisor_tb;
    import sswd_pkg::*;
    // short counts so the run stays brief
    localparam int HOLD = 40;
    localparam int PBL = 10;
    localparam int TO_A = 100;
    localparam int TO_B = 200;
    localparam int TO_C = 300;
    logic sys_clk, arst_n, ok_t, ok_l, margin, kick_en, press, kick_n, man_n, reset_out, reset_out_n;
    logic [1:0] tsel;
    logic [7:0] kick_period;
    int err_count, total_checks, n;
    int lims [4] = '{TO_A, TO_B, TO_C, TO_A};

    sswd_supervisor #(.HOLD_CYC(32'(HOLD)), .PB_LOW_CYC(32'(PBL)), .TO_SHORT_CYC(32'(TO_A)),
        .TO_MID_CYC(32'(TO_B)), .TO_LONG_CYC(32'(TO_C))) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .supply_ok_tight(ok_t), .supply_ok_loose(ok_l), .trip_margin_sel(margin), .timeout_select(tsel),
        .manual_reset_n(man_n), .watchdog_kick_n(kick_n), .reset_out(reset_out), .reset_out_n(reset_out_n));

    sswd_host_model u_host (.sys_clk(sys_clk), .kick_en(kick_en), .kick_period(kick_period),
        .press(press), .watchdog_kick_n(kick_n), .manual_reset_n(man_n));

    // ============================================================
    // helpers
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // cycles until reset_out shows v, bounded so a hang cannot stall here
    task automatic wait_out(input logic v, input int lim, output int c);
        c = 0;
        while (reset_out !== v && c < lim) begin
            cyc(1);
            c++;
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        `CHK(v >= lo && v <= hi, 1'b1)
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_powerup();
        `CHK(reset_out, 1'b1);
        @(posedge sys_clk) arst_n <= 1'b1;
        wait_out(1'b0, 200, n);
        rng(n, HOLD, HOLD + 5);
    endtask

    task automatic t_supply();
        // tight margin selected: loose comparator alone must not trip
        @(posedge sys_clk) ok_l <= 1'b0;
        cyc(20);
        `CHK(reset_out, 1'b0);
        @(posedge sys_clk) ok_l <= 1'b1;
        @(posedge sys_clk) ok_t <= 1'b0;
        wait_out(1'b1, 10, n);
        rng(n, 1, 4);
        cyc(100);
        `CHK(reset_out, 1'b1);
        @(posedge sys_clk) ok_t <= 1'b1;
        cyc(20);
        // a short dip during the hold must restart it
        @(posedge sys_clk) ok_t <= 1'b0;
        cyc(3);
        @(posedge sys_clk) ok_t <= 1'b1;
        wait_out(1'b0, 200, n);
        rng(n, HOLD, HOLD + 6);
        // loose margin: tight comparator alone no longer trips
        @(posedge sys_clk) margin <= 1'b1;
        cyc(5);
        @(posedge sys_clk) ok_t <= 1'b0;
        cyc(20);
        `CHK(reset_out, 1'b0);
        @(posedge sys_clk) ok_l <= 1'b0;
        wait_out(1'b1, 10, n);
        rng(n, 1, 4);
        @(posedge sys_clk) ok_l <= 1'b1;
        ok_t <= 1'b1;
        wait_out(1'b0, 200, n);
        rng(n, HOLD, HOLD + 5);
    endtask

    task automatic t_manual();
        @(posedge sys_clk) press <= 1'b1;
        cyc(PBL - 5);
        @(posedge sys_clk) press <= 1'b0;
        cyc(30);
        `CHK(reset_out, 1'b0);
        @(posedge sys_clk) press <= 1'b1;
        wait_out(1'b1, 40, n);
        rng(n, PBL, PBL + 5);
        cyc(60);
        `CHK(reset_out, 1'b1);
        @(posedge sys_clk) press <= 1'b0;
        wait_out(1'b0, 200, n);
        rng(n, HOLD, HOLD + 5);
    endtask

    // kicks just inside the shortest timeout keep reset away
    task automatic t_kick();
        @(posedge sys_clk) kick_period <= 8'h5a;
        n = 0;
        repeat (1000) begin
            cyc(1);
            n += int'(reset_out !== 1'b0);
        end
        `CHK(n, 0);
    endtask

    task automatic t_watchdog();
        @(posedge sys_clk) kick_en <= 1'b0;
        wait_out(1'b1, 400, n);
        rng(n, 1, TO_A + 5);
        for (int k = 0; k < 4; k++) begin
            // select moves one edge into the hold, so one hold cycle is already gone
            @(posedge sys_clk) tsel <= 2'(k);
            wait_out(1'b0, 200, n);
            rng(n, HOLD - 1, HOLD + 2);
            wait_out(1'b1, 400, n);
            rng(n, lims[k] - 2, lims[k] + 2);
        end
    endtask

    // ============================================================
    // clock, complement watch, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) if (arst_n === 1'b1) `CHK(reset_out_n, ~reset_out)

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        arst_n = 1'b0;
        ok_t = 1'b1;
        ok_l = 1'b1;
        margin = 1'b0;
        tsel = 2'h0;
        kick_en = 1'b1;
        kick_period = 8'h1e;
        press = 1'b0;
        cyc(3);
        t_powerup();
        t_supply();
        t_manual();
        t_kick();
        t_watchdog();
        finish_test();
    end
endmodule

//--- sswd_sync.sv
// two-flop synchroniser for the supervisor's asynchronous pins
`timescale 1ns/1ps
module sswd_sync
    import sswd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input sswd_pkg::sswd_pins_t pins_async,
    output sswd_pkg::sswd_pins_t pins_sync
);
    import sswd_pkg::*;

    sswd_pins_t stage1;
    sswd_pins_t stage2;
    sswd_pins_t next_stage1;
    sswd_pins_t next_stage2;

    // first stage feeds only the second stage
    always_comb begin
        next_stage1 = pins_async;
        next_stage2 = stage1;
    end

    // ============================================================
    // registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= SSWD_PINS_RST;
            stage2 <= SSWD_PINS_RST;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign pins_sync = stage2;
endmodule
